// ==== design/uradr_pkg.sv ====
/*
  Constants for the serial receiver with address filtering: register
  offsets, status and mode bit positions, reset values and encodings.
  Assumes a single 250 MHz core clock and a plain strobe register port.
*/
package uradr_pkg;
  // Register word offsets on the plain port
  localparam logic [3:0] URADR_ADDR_MODE   = 4'h0;
  localparam logic [3:0] URADR_ADDR_STATUS = 4'h1;
  localparam logic [3:0] URADR_ADDR_DATA   = 4'h2;
  localparam logic [3:0] URADR_ADDR_BAUD   = 4'h3;
  localparam logic [3:0] URADR_ADDR_IRQ    = 4'h4;
  // Mode register fields
  localparam int MODE_EN_BIT    = 15;
  localparam int MODE_DATA_PARITY_SELECT_LSB = 1;
  localparam int MODE_STOP_BIT_SELECT_BIT = 0;
  // Status / control register fields
  localparam int STA_DA_BIT    = 0;
  localparam int STA_OVERRUN_FLAG_BIT  = 1;
  localparam int STA_FRAMING_ERR_FLAG_BIT  = 2;
  localparam int STA_PARITY_ERR_FLAG_BIT  = 3;
  localparam int STA_IDLE_BIT  = 4;
  localparam int STA_ADDR_DETECT_EN_BIT = 5;
  localparam int STA_ISEL_LSB  = 6;
  // Data/parity select encodings
  localparam logic [1:0] PD_8N  = 2'h0;
  localparam logic [1:0] PD_8E  = 2'h1;
  localparam logic [1:0] PD_8O  = 2'h2;
  localparam logic [1:0] PD_9N  = 2'h3;
  // Interrupt select encodings
  localparam logic [1:0] ISEL_THREE = 2'h2;
  localparam logic [1:0] ISEL_FULL  = 2'h3;
  // Oversampling and majority sample points within a bit
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] SMP_A    = 4'h7;
  localparam logic [3:0] SMP_B    = 4'h8;
  localparam logic [3:0] SMP_C    = 4'h9;
  localparam logic [3:0] START_MID = 4'h7;
  // Reset values
  localparam logic [15:0] BAUD_RST = 16'h0000;
  typedef enum logic [3:0] {
    URADR_IDLE  = 4'b0001,
    URADR_START = 4'b0010,
    URADR_DATA  = 4'b0100,
    URADR_BREAK = 4'b1000
  } uradr_state_t;
endpackage : uradr_pkg

// ==== design/uradr_rx.sv ====
/*
  Receive half of an asynchronous serial port: 16x oversampling,
  majority vote, shift register, 4 x 9-bit FIFO with per-word error
  flags, overrun handling, selectable receive flag and address filter.
  Assumes the serial pin is asynchronous (synchronised here) and that
  software uses the one-cycle strobe register port.
*/
// The register offsets and the strobed register port are this design's own decisions.
module uradr_rx #(
  parameter int DEPTH = 4,
  parameter int WIDTH = 9
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        rst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // Serial line and receive flag
  input  wire logic        serial_in_pin,
  output logic             rx_irq_flag
);
  import uradr_pkg::*;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam int EW = WIDTH + 1; // word plus framing; parity re-judged

  // Software state
  logic [15:0]  mode_reg, next_mode_reg;
  logic [15:0]  baud_divisor_reg, next_baud;
  logic         addr_detect_en, next_addr_detect_en;
  logic [1:0]   rx_irq_select, next_isel;
  logic         overrun_flag, next_overrun;
  logic         irq_q, next_irq;
  logic [15:0]  rdata_q, next_rdata;
  // Receiver state
  uradr_state_t state, next_state;
  logic [15:0]  baud_cnt, next_baud_cnt;
  logic [3:0]   ovs, next_ovs;
  logic [2:0]   votes, next_votes;
  logic [3:0]   bit_idx, next_bit_idx;
  logic [WIDTH-1:0] rx_shift_reg, next_shift;
  logic         pend, next_pend;       // word held in shift register
  logic         pend_framing_err_flag, next_pend_framing_err_flag;
  // FIFO
  logic [EW-1:0] mem [DEPTH];
  logic [PW-1:0] wp, next_wp, rp, next_rp;
  logic [CW-1:0] cnt, next_cnt;
  // Synchroniser
  logic          pin_s1, pin_s2, pin_d;

  logic        module_enable, nine_bit, tick, push, pop, bit_val, par_bad;
  logic [1:0]  data_parity_select;
  logic [3:0]  last_idx, data_bits;
  logic [EW-1:0] head;
  logic [15:0] status_ctrl_reg;
  logic        ovr_set;
  assign module_enable      = mode_reg[MODE_EN_BIT];
  assign data_parity_select = mode_reg[MODE_DATA_PARITY_SELECT_LSB +: 2];
  assign nine_bit           = (data_parity_select == PD_9N);
  assign head               = mem[rp];
  assign bit_val            = (votes[0] & votes[1]) | (votes[0] & votes[2])
                            | (votes[1] & votes[2]);
  // Frame length: 8 data, +1 parity or ninth bit, +1 or 2 stop bits
  assign data_bits = (data_parity_select == PD_8N) ? 4'h8 : 4'h9;
  assign last_idx  = data_bits + (mode_reg[MODE_STOP_BIT_SELECT_BIT] ? 4'h2 : 4'h1);
  // Parity judged on the head word; meaningless in 9-bit format
  assign par_bad  = (data_parity_select == PD_8E) ? ^head[8:0]
                  : (data_parity_select == PD_8O) ? ~^head[8:0]
                  : 1'b0;
  // Status shows head flags; idle while the receiver state is URADR_IDLE
  always_comb begin
    status_ctrl_reg = '0;
    status_ctrl_reg[STA_DA_BIT]    = (cnt != '0);
    status_ctrl_reg[STA_OVERRUN_FLAG_BIT]  = overrun_flag;
    status_ctrl_reg[STA_FRAMING_ERR_FLAG_BIT]  = (cnt != '0) & head[WIDTH];
    status_ctrl_reg[STA_PARITY_ERR_FLAG_BIT]  = (cnt != '0) & par_bad;
    status_ctrl_reg[STA_IDLE_BIT]  = (state == URADR_IDLE);
    status_ctrl_reg[STA_ADDR_DETECT_EN_BIT] = addr_detect_en;
    status_ctrl_reg[STA_ISEL_LSB +: 2] = rx_irq_select;
  end

  // Two flops before the line logic; edge seen only on the second
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      pin_d  <= 1'b1;
    end else begin
      pin_s1 <= serial_in_pin;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
    end
  end
  // Divider gives the 16x oversample enable pulse
  assign tick = module_enable && (baud_cnt == '0);
  assign pop  = reg_rd && (reg_addr == URADR_ADDR_DATA) && (cnt != '0);

  // Receiver sequencing, shift register and transfer decision
  always_comb begin
    next_state     = state;
    next_baud_cnt  = baud_cnt;
    next_ovs       = ovs;
    next_votes     = votes;
    next_bit_idx   = bit_idx;
    next_shift     = rx_shift_reg;
    next_pend      = pend;
    next_pend_framing_err_flag = pend_framing_err_flag;
    push           = 1'b0;
    ovr_set        = 1'b0;
    if (module_enable) begin
      next_baud_cnt = (baud_cnt == '0) ? baud_divisor_reg : baud_cnt - 16'h1;
    end
    // A held word moves once the FIFO has room and overrun is clear
    if (pend && !overrun_flag && cnt != CW'(DEPTH)) begin
      push      = 1'b1;
      next_pend = 1'b0;
    end
    if (tick) begin
      case (state)
        URADR_IDLE: begin
          if (pin_d && !pin_s2) begin
            next_state = URADR_START;
            next_ovs   = '0;
          end
        end
        URADR_START: begin
          // Check mid start bit, then run out the whole bit period
          next_ovs = ovs + 4'h1;
          if (ovs == START_MID && pin_s2) begin
            next_state = URADR_IDLE; // glitch, not a start
          end else if (ovs == OVS_LAST) begin
            next_state   = URADR_DATA;
            next_bit_idx = '0;
            if (!pend) next_shift = '0;
          end
        end
        URADR_DATA: begin
          next_ovs = ovs + 4'h1;
          if (ovs == SMP_A) next_votes[0] = pin_s2;
          if (ovs == SMP_B) next_votes[1] = pin_s2;
          if (ovs == SMP_C) next_votes[2] = pin_s2;
          if (ovs == OVS_LAST) begin // one shift per bit period
            next_bit_idx = bit_idx + 4'h1;
            if (!pend && bit_idx < data_bits) begin // held word kept
              next_shift[bit_idx] = bit_val;
            end
            if (bit_idx == last_idx - 4'h1) begin
              next_state = bit_val ? URADR_IDLE : URADR_BREAK;
              if (pend) begin
                ovr_set = 1'b1; // later word lost while one is held
              end else if (nine_bit && addr_detect_en && !next_shift[8]) begin
                // Data word filtered out
              end else begin
                ovr_set        = (cnt == CW'(DEPTH)); // fifth word
                next_pend      = 1'b1;
                next_pend_framing_err_flag = !bit_val;
              end
            end
          end
        end
        URADR_BREAK: begin
          if (pin_s2) next_state = URADR_IDLE;
        end
        default: next_state = URADR_IDLE;
      endcase
    end
    if (!module_enable) begin
      next_state    = URADR_IDLE;
      next_pend     = 1'b0;
      next_baud_cnt = '0;
      push          = 1'b0;
    end
  end

  // FIFO pointers and occupancy; overrun clear or disable flushes
  always_comb begin
    next_wp  = wp;
    next_rp  = rp;
    next_cnt = cnt;
    if (push) next_wp = (wp == PW'(DEPTH - 1)) ? '0 : wp + PW'(1);
    if (pop)  next_rp = (rp == PW'(DEPTH - 1)) ? '0 : rp + PW'(1);
    if (push && !pop) next_cnt = cnt + CW'(1);
    if (pop && !push) next_cnt = cnt - CW'(1);
    if (!module_enable || (overrun_flag && !next_overrun)) begin
      next_wp  = '0;
      next_rp  = '0;
      next_cnt = '0;
    end
  end
  // Register writes, overrun and receive flag; hardware set beats clear
  always_comb begin
    next_mode_reg = mode_reg;
    next_baud     = baud_divisor_reg;
    next_addr_detect_en    = addr_detect_en;
    next_isel     = rx_irq_select;
    next_overrun  = overrun_flag;
    next_irq      = irq_q;
    if (reg_wr && reg_addr == URADR_ADDR_MODE) begin
      next_mode_reg = reg_wdata;
    end else if (reg_wr && reg_addr == URADR_ADDR_BAUD) begin
      next_baud = reg_wdata;
    end else if (reg_wr && reg_addr == URADR_ADDR_STATUS) begin
      next_addr_detect_en = reg_wdata[STA_ADDR_DETECT_EN_BIT];
      next_isel  = reg_wdata[STA_ISEL_LSB +: 2];
      if (!reg_wdata[STA_OVERRUN_FLAG_BIT]) next_overrun = 1'b0;
    end else if (reg_wr && reg_addr == URADR_ADDR_IRQ) begin
      next_irq = 1'b0;
    end
    if (ovr_set) next_overrun = 1'b1;
    if (push) begin
      case (rx_irq_select)
        ISEL_THREE: if (cnt + CW'(1) >= CW'(DEPTH - 1)) next_irq = 1'b1;
        ISEL_FULL:  if (cnt + CW'(1) == CW'(DEPTH)) next_irq = 1'b1;
        default:    next_irq = 1'b1;
      endcase
    end
    if (!module_enable) next_overrun = 1'b0;
  end

  // Read data answered one cycle after the strobe, zero otherwise
  always_comb begin
    next_rdata = '0;
    if (reg_rd) begin
      if (reg_addr == URADR_ADDR_MODE) begin
        next_rdata = mode_reg;
      end else if (reg_addr == URADR_ADDR_STATUS) begin
        next_rdata = status_ctrl_reg;
      end else if (reg_addr == URADR_ADDR_DATA) begin
        next_rdata = 16'(head[WIDTH-1:0]);
      end else if (reg_addr == URADR_ADDR_BAUD) begin
        next_rdata = baud_divisor_reg;
      end else if (reg_addr == URADR_ADDR_IRQ) begin
        next_rdata = {15'h0, irq_q};
      end
    end
  end

  // Word storage: an array, write only on push
  always_ff @(posedge core_clk) begin
    if (push) mem[wp] <= {pend_framing_err_flag, rx_shift_reg};
  end
  // State registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mode_reg         <= '0;
      baud_divisor_reg <= BAUD_RST;
      addr_detect_en   <= 1'b0;
      rx_irq_select    <= '0;
      overrun_flag     <= 1'b0;
      irq_q            <= 1'b0;
      rdata_q          <= '0;
      state            <= URADR_IDLE;
      baud_cnt         <= '0;
      ovs              <= '0;
      votes            <= '0;
      bit_idx          <= '0;
      rx_shift_reg     <= '0;
      pend             <= 1'b0;
      pend_framing_err_flag        <= 1'b0;
      wp               <= '0;
      rp               <= '0;
      cnt              <= '0;
    end else begin
      mode_reg         <= next_mode_reg;
      baud_divisor_reg <= next_baud;
      addr_detect_en   <= next_addr_detect_en;
      rx_irq_select    <= next_isel;
      overrun_flag     <= next_overrun;
      irq_q            <= next_irq;
      rdata_q          <= next_rdata;
      state            <= next_state;
      baud_cnt         <= next_baud_cnt;
      ovs              <= next_ovs;
      votes            <= next_votes;
      bit_idx          <= next_bit_idx;
      rx_shift_reg     <= next_shift;
      pend             <= next_pend;
      pend_framing_err_flag        <= next_pend_framing_err_flag;
      wp               <= next_wp;
      rp               <= next_rp;
      cnt              <= next_cnt;
    end
  end

  assign reg_rdata   = rdata_q;
  assign rx_irq_flag = irq_q;
  // Checks
  property p_push_blocked;
    @(posedge core_clk) disable iff (rst)
      overrun_flag |-> !push;
  endproperty
  a_push_blocked: assert property (p_push_blocked)
    else $error("transfer into FIFO during overrun");
  property p_flush;
    @(posedge core_clk) disable iff (rst)
      ($fell(overrun_flag) && module_enable) |-> (cnt == '0);
  endproperty
  a_flush: assert property (p_flush)
    else $error("FIFO not emptied on overrun clear");
  property p_da;
    @(posedge core_clk) disable iff (rst)
      reg_rd && reg_addr == URADR_ADDR_STATUS
      |=> reg_rdata[STA_DA_BIT] == ($past(cnt) != '0);
  endproperty
  a_da: assert property (p_da)
    else $error("data-available bit wrong");
  property p_full_irq;
    @(posedge core_clk) disable iff (rst)
      (push && rx_irq_select == ISEL_FULL && cnt == CW'(DEPTH - 1) && !pop)
      |=> rx_irq_flag && cnt == CW'(DEPTH);
  endproperty
  a_full_irq: assert property (p_full_irq)
    else $error("full-level receive flag missing");
  property p_any_irq;
    @(posedge core_clk) disable iff (rst)
      (push && !rx_irq_select[1]) |=> rx_irq_flag;
  endproperty
  a_any_irq: assert property (p_any_irq)
    else $error("per-word receive flag missing");
  property p_disable;
    @(posedge core_clk) disable iff (rst)
      !module_enable |=> cnt == '0 && !overrun_flag && state == URADR_IDLE;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disable did not reset receiver");
  property p_no_overflow;
    @(posedge core_clk) disable iff (rst)
      cnt <= CW'(DEPTH) && !(push && cnt == CW'(DEPTH) && !pop);
  endproperty
  a_no_overflow: assert property (p_no_overflow)
    else $error("FIFO overflow");
  property p_pop;
    @(posedge core_clk) disable iff (rst)
      (pop && !push && module_enable && !(overrun_flag && !next_overrun))
      |=> cnt == $past(cnt) - CW'(1);
  endproperty
  a_pop: assert property (p_pop)
    else $error("data read did not remove head");
endmodule : uradr_rx

// ==== verification/uradr_tx_model.sv ====
/*
  Behavioural remote transmitter that drives the serial receive pin.
  Assumes the bench pulses go for one core_clk cycle, then waits on busy.
*/
module uradr_tx_model #(
  parameter int BIT_CLKS = 16
) (
  // Clock
  input  wire logic       core_clk,
  // Frame request
  input  wire logic       go,
  input  wire logic [8:0] word,
  input  wire logic [3:0] nbits,
  input  wire logic       bad_stop,
  // Serial line and status
  output logic            line,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 1ps;

  // Hold the line at one level for whole bit times
  task automatic hold(input logic lvl, input int bits);
    line <= lvl;
    repeat (bits * BIT_CLKS) @(posedge core_clk);
  endtask : hold

  // Line idles high, as a pulled-up receive pin would. Frame: start,
  // data LSB first, stop; a bad stop keeps the line low four more
  // bits, so it also serves as a break longer than a frame
  initial begin
    line = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge core_clk);
      if (go) begin
        busy <= 1'b1;
        hold(1'b0, 1);
        for (int i = 0; i < nbits; i++) begin
          hold(word[i], 1);
        end
        if (bad_stop) begin
          hold(1'b0, 4);
        end
        hold(1'b1, 2);
        busy <= 1'b0;
      end
    end
  end
endmodule : uradr_tx_model

// ==== verification/test_uradr_rx.sv ====
/*
  Self-checking bench for the serial receiver with address filtering.
  Assumes the register map of uradr_pkg and a baud divisor of zero,
  so one bit lasts sixteen core_clk cycles.
*/
module test_uradr_rx;
  timeunit 1ns;
  timeprecision 1ps;
  import uradr_pkg::*;

  // Design ports
  logic        core_clk;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        serial_in_pin;
  logic        rx_irq_flag;
  // Transmitter model controls and bench state
  logic        tx_go;
  logic [8:0]  tx_word;
  logic [3:0]  tx_nbits;
  logic        tx_bad;
  logic        tx_busy;
  logic [15:0] rdat;
  int          mismatches;
  int          n_compared;

  // Parity cases: format, frame word with parity in bit 8, error
  localparam logic [1:0] P_MODE [5] = '{PD_8E, PD_8E, PD_8O, PD_8O, PD_9N};
  localparam logic [8:0] P_WORD [5] = '{9'h003, 9'h007, 9'h007, 9'h003,
                                         9'h107};
  localparam logic       P_ERR  [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};

  uradr_rx uradr_rx_inst (
    .core_clk      (core_clk),
    .rst           (rst),
    .reg_addr      (reg_addr),
    .reg_wdata     (reg_wdata),
    .reg_wr        (reg_wr),
    .reg_rd        (reg_rd),
    .reg_rdata     (reg_rdata),
    .serial_in_pin (serial_in_pin),
    .rx_irq_flag   (rx_irq_flag)
  );

  uradr_tx_model uradr_tx_model_inst (
    .core_clk (core_clk),
    .go       (tx_go),
    .word     (tx_word),
    .nbits    (tx_nbits),
    .bad_stop (tx_bad),
    .line     (serial_in_pin),
    .busy     (tx_busy)
  );

  // 250 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic final_report();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp,
                       input string what);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h", $time, what, got);
    end
  endtask : chk16

  // Let the edge's updates land before looking at the flag
  task automatic flag_chk(input logic exp, input string what);
    #1;
    n_compared++;
    if (rx_irq_flag !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : flag_chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic st_chk(input logic [15:0] m, input logic [15:0] e,
                        input string what);
    rd(URADR_ADDR_STATUS, rdat);
    chk16(rdat & m, e, what);
  endtask : st_chk

  task automatic start_frame(input logic [8:0] w, input logic [3:0] n,
                             input logic bad);
    @(posedge core_clk);
    tx_word  <= w;
    tx_nbits <= n;
    tx_bad   <= bad;
    tx_go    <= 1'b1;
    @(posedge core_clk);
    tx_go    <= 1'b0;
  endtask : start_frame

  // Bounded wait for the far side to finish its frame
  task automatic wait_frame();
    int k;
    k = 0;
    @(posedge core_clk);
    while (tx_busy === 1'b1 && k < 3000) begin
      @(posedge core_clk);
      k++;
    end
    if (k == 3000) begin
      mismatches++;
      $display("CHECK FAILED at %0t: frame hang", $time);
      final_report();
    end
  endtask : wait_frame

  task automatic send(input logic [8:0] w, input logic [3:0] n,
                      input logic bad);
    start_frame(w, n, bad);
    wait_frame();
  endtask : send

  initial begin
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    tx_go = 1'b0;
    tx_word = 9'h000;
    tx_nbits = 4'h8;
    tx_bad = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    // Reset state and an unmapped index
    rd(URADR_ADDR_MODE, rdat);
    chk16(rdat, 16'h0000, "mode reset");
    st_chk(16'h001f, 16'h0010, "status reset");
    wr(4'h7, 16'hffff);
    rd(4'h7, rdat);
    chk16(rdat, 16'h0000, "unmapped read");
    $display("test reset done");
    // Plain 8N1 word; idle drops while a frame is on the line
    wr(URADR_ADDR_BAUD, 16'h0000);
    wr(URADR_ADDR_MODE, 16'h8000);
    start_frame(9'h0a5, 4'h8, 1'b0);
    repeat (40) @(posedge core_clk);
    st_chk(16'h0010, 16'h0000, "idle in frame");
    wait_frame();
    flag_chk(1'b1, "flag per word");
    st_chk(16'h0011, 16'h0011, "data avail");
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h00a5, "8N1 word");
    st_chk(16'h0001, 16'h0000, "popped");
    wr(URADR_ADDR_IRQ, 16'h0000);
    flag_chk(1'b0, "flag cleared");
    $display("test 8N1 done");
    // Parity formats, good and bad, none in nine-bit format
    for (int i = 0; i < 5; i++) begin
      wr(URADR_ADDR_MODE, {1'b1, 12'h000, P_MODE[i], 1'b0});
      send(P_WORD[i], 4'h9, 1'b0);
      st_chk(16'h0009, {12'h000, P_ERR[i], 3'h1}, "parity");
      rd(URADR_ADDR_DATA, rdat);
      chk16(rdat, {7'h00, P_WORD[i]}, "parity word");
    end
    $display("test parity done");
    // Break then a good word: flags travel with each word
    wr(URADR_ADDR_MODE, 16'h8000);
    send(9'h000, 4'h8, 1'b1);
    send(9'h05a, 4'h8, 1'b0);
    st_chk(16'h0015, 16'h0015, "break head");
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h0000, "break word");
    st_chk(16'h0015, 16'h0011, "next head");
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h005a, "after break");
    $display("test break done");
    // Fill levels under select 10 then 11; disable empties between
    for (int s = 2; s < 4; s++) begin
      wr(URADR_ADDR_STATUS, {8'h00, s[1:0], 6'h00});
      for (int n = 1; n <= 4; n++) begin
        wr(URADR_ADDR_IRQ, 16'h0000);
        send(9'(n), 4'h8, 1'b0);
        flag_chk((s == 2) ? (n >= 3) : (n == 4), "fill");
      end
      if (s == 2) begin
        wr(URADR_ADDR_MODE, 16'h0000);
        st_chk(16'h001f, 16'h0010, "disable");
        wr(URADR_ADDR_MODE, 16'h8000);
      end
    end
    $display("test fill done");
    // Fifth word overruns; later words stay out of the FIFO
    send(9'h0ee, 4'h8, 1'b0);
    st_chk(16'h0003, 16'h0003, "overrun");
    for (int n = 1; n <= 4; n++) begin
      rd(URADR_ADDR_DATA, rdat);
      chk16(rdat, 16'(n), "fifo order");
      if (n == 1) begin
        send(9'h0dd, 4'h8, 1'b0);
      end
    end
    st_chk(16'h0003, 16'h0002, "blocked");
    wr(URADR_ADDR_STATUS, 16'h00c0);
    st_chk(16'h0003, 16'h0001, "overrun cleared");
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h00ee, "held fifth word");
    $display("test overrun done");
    // Address filter in nine-bit format, ignored in eight-bit
    wr(URADR_ADDR_MODE, {1'b1, 12'h000, PD_9N, 1'b0});
    wr(URADR_ADDR_STATUS, 16'h0020);
    wr(URADR_ADDR_IRQ, 16'h0000);
    send(9'h055, 4'h9, 1'b0);
    flag_chk(1'b0, "filtered flag");
    st_chk(16'h0001, 16'h0000, "filtered");
    send(9'h1aa, 4'h9, 1'b0);
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h01aa, "address word");
    wr(URADR_ADDR_STATUS, 16'h0000);
    send(9'h033, 4'h9, 1'b0);
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h0033, "data word");
    wr(URADR_ADDR_STATUS, 16'h0020);
    wr(URADR_ADDR_MODE, 16'h8000);
    send(9'h055, 4'h8, 1'b0);
    rd(URADR_ADDR_DATA, rdat);
    chk16(rdat, 16'h0055, "8-bit ignores filter");
    $display("test address done");
    final_report();
  end
endmodule : test_uradr_rx
